// ===== core/rrot_pkg.sv
/*
  constants and carrier types for the rotate-right datapath slice.
  assumes one core clock; decoder presents one instruction word per issue.
*/
// Notes on behaviour
// - read any file register, index 0 to 255
// - through-link: carry to msb, lsb to carry
// - destination clear: result to working accumulator
// - destination set: result back to source register
package rrot_pkg;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [6:0] RROT_OP_WITH_LINK = 7'h0c;
  localparam logic [6:0] RROT_OP_PLAIN = 7'h10;
  localparam int RROT_OP_POS = 9;
  localparam int RROT_DEST_POS = 8;
  localparam logic [7:0] RROT_ACC_RESET = 8'h00;
  localparam logic RROT_CARRY_RESET = 1'b0;

  typedef struct packed {
    logic [6:0] opcode;
    logic dest;
    logic [7:0] index;
  } rrot_instr_t;

  typedef struct packed {
    logic en;
    logic [7:0] index;
    logic [7:0] data;
  } rrot_wr_t;

  typedef enum logic [3:0] {
    RROT_DECODE = 4'b0001,
    RROT_READ = 4'b0010,
    RROT_EXEC = 4'b0100,
    RROT_WRITE = 4'b1000
  } rrot_phase_t;
endpackage

// ===== core/rrot_alu.sv
/*
  rotate-right datapath: decode, read, execute, write over four core clocks.
  assumes a register file with a combinational read port and one write port.
*/
`timescale 1ns/1ps
module rrot_alu
  import rrot_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // decoder side
  input wire logic issue,
  input wire rrot_instr_t instr,
  output logic busy,
  output logic done,
  // register file side
  output logic [7:0] rdIndex,
  input wire logic [7:0] rdData,
  output rrot_wr_t fileWr,
  // architectural state
  output logic [7:0] workAcc,
  output logic carryFlag
);
  rrot_phase_t phase_ff;
  rrot_instr_t inst_ff;
  logic [7:0] operand_ff;
  logic [7:0] result_ff;
  logic linkOut_ff;
  logic isLink;
  logic isPlain;
  logic [7:0] nxt_result;
  logic doneOut_ff;

  assign isLink = (inst_ff.opcode == RROT_OP_WITH_LINK);
  assign isPlain = (inst_ff.opcode == RROT_OP_PLAIN);
  // busy covers read, execute and write
  assign busy = (phase_ff != RROT_DECODE);
  assign done = doneOut_ff;
  assign rdIndex = inst_ff.index;

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_ff <= RROT_DECODE;
      inst_ff <= '0;
    end else if (clkEn) begin
      case (phase_ff)
        RROT_DECODE: begin
          if (issue && (instr.opcode == RROT_OP_WITH_LINK || instr.opcode == RROT_OP_PLAIN)) begin
            inst_ff <= instr;
            phase_ff <= RROT_READ;
          end
        end
        RROT_READ: phase_ff <= RROT_EXEC;
        RROT_EXEC: phase_ff <= RROT_WRITE;
        RROT_WRITE: phase_ff <= RROT_DECODE;
        default: phase_ff <= RROT_DECODE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read and execute
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      operand_ff <= 8'h00;
    end else if (clkEn && phase_ff == RROT_READ) begin
      operand_ff <= rdData;
    end
  end

  always_comb begin
    // through-link feeds the old carry into bit 7
    if (isLink) begin
      nxt_result = {carryFlag, operand_ff[7:1]};
    end else begin
      nxt_result = {operand_ff[0], operand_ff[7:1]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      result_ff <= 8'h00;
      linkOut_ff <= RROT_CARRY_RESET;
    end else if (clkEn && phase_ff == RROT_EXEC) begin
      result_ff <= nxt_result;
      linkOut_ff <= operand_ff[0];
    end
  end

  // ----------------------------------------------------------------
  // write to destination
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      workAcc <= RROT_ACC_RESET;
    end else if (clkEn && phase_ff == RROT_WRITE && !inst_ff.dest) begin
      workAcc <= result_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      carryFlag <= RROT_CARRY_RESET;
    end else if (clkEn && phase_ff == RROT_WRITE && isLink) begin
      carryFlag <= linkOut_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fileWr <= '0;
      doneOut_ff <= 1'b0;
    end else if (clkEn) begin
      fileWr.en <= (phase_ff == RROT_WRITE) && inst_ff.dest;
      fileWr.index <= inst_ff.index;
      fileWr.data <= result_ff;
      doneOut_ff <= (phase_ff == RROT_WRITE);
    end else begin
      // clearing en on a stall keeps a frozen write from repeating
      fileWr.en <= 1'b0;
      doneOut_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seqIssue;
    phase_ff == RROT_DECODE && issue && clkEn &&
      (instr.opcode == RROT_OP_WITH_LINK || instr.opcode == RROT_OP_PLAIN);
  endsequence

  chk_four_phase_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seqIssue ##1 clkEn[*3] |=> done)
    else $error("instruction did not finish in four phases");

  chk_link_carry_msb: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_ff == RROT_WRITE && clkEn && isLink |-> result_ff[7] == carryFlag)
    else $error("old carry not in msb");

  chk_link_carry_lsb: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_ff == RROT_EXEC && clkEn && isLink ##1 clkEn |=> carryFlag == $past(operand_ff[0], 2))
    else $error("carry not taken from lsb");

  chk_plain_rotate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_ff == RROT_EXEC && clkEn && isPlain |=>
      result_ff == {$past(operand_ff[0]), $past(operand_ff[7:1])})
    else $error("plain rotate result wrong");

  chk_plain_no_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    isPlain && busy |=> $stable(carryFlag))
    else $error("plain rotate changed carry");

  chk_acc_dest: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_ff == RROT_WRITE && clkEn && !inst_ff.dest |=> workAcc == $past(result_ff) && !fileWr.en)
    else $error("accumulator destination wrong");

  chk_file_dest: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_ff == RROT_WRITE && clkEn && inst_ff.dest |=>
      fileWr.en && fileWr.data == $past(result_ff) && $stable(workAcc))
    else $error("file destination wrong");

  chk_read_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seqIssue |=> rdIndex == $past(instr.index))
    else $error("read index not taken from operand");

  chk_write_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fileWr.en |-> fileWr.index == inst_ff.index)
    else $error("write index differs from read");

  // ----------------------------------------------------------------
  // sequencing, hold and through-link rotate checks
  // ----------------------------------------------------------------
  // unknown opcode seen while idle
  sequence seqRefused;
    phase_ff == RROT_DECODE && issue && clkEn &&
      instr.opcode != RROT_OP_WITH_LINK && instr.opcode != RROT_OP_PLAIN;
  endsequence

  chk_refuse_opcode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seqRefused |=> !busy)
    else $error("unknown opcode was taken");

  chk_issue_to_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seqIssue |=> phase_ff == RROT_READ)
    else $error("taken instruction did not enter read phase");

  chk_done_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done |=> !done)
    else $error("done stood longer than one cycle");

  chk_file_en_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fileWr.en |=> !fileWr.en)
    else $error("file write stood longer than one cycle");

  chk_file_with_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fileWr.en |-> done)
    else $error("file write outside the write phase");

  chk_acc_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(phase_ff == RROT_WRITE && clkEn && !inst_ff.dest) |=> $stable(workAcc))
    else $error("accumulator changed without a write");

  chk_carry_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(phase_ff == RROT_WRITE && clkEn && isLink) |=> $stable(carryFlag))
    else $error("carry changed outside a through-link write");

  chk_link_rotate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_ff == RROT_EXEC && clkEn && isLink |=>
      result_ff == {$past(carryFlag), $past(operand_ff[7:1])})
    else $error("through-link rotate result wrong");

  chk_frozen_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clkEn |=> $stable(phase_ff))
    else $error("phase moved while clock enable low");
endmodule

// ===== dv/test_rotate_right_alu_ops.sv
/*
  bench for the rotate-right datapath slice.
  assumes a combinational register file, modelled here.
*/
`timescale 1ns/1ps
module test_rotate_right_alu_ops;
  import rrot_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic issue = 1'b0;
  rrot_instr_t instr = '0;
  logic busy, done, carryFlag;
  logic [7:0] rdIndex, workAcc;
  rrot_wr_t fileWr;
  logic [7:0] mem [256];
  logic [7:0] expAcc = 8'h00;
  logic expC = 1'b0;
  int n_errors = 0;
  int checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  rrot_alu dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .issue(issue),
    .instr(instr), .busy(busy), .done(done), .rdIndex(rdIndex), .rdData(mem[rdIndex]),
    .fileWr(fileWr), .workAcc(workAcc), .carryFlag(carryFlag));
  always @(posedge clk_sys) begin
    if (fileWr.en === 1'b1) mem[fileWr.index] <= fileWr.data;
  end
  // ---------------
  // tasks
  // ---------------
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic run_op(input logic [6:0] op, input logic d, input logic [7:0] idx,
      input logic [7:0] v);
    logic [7:0] res;
    logic got;
    res = (op == RROT_OP_WITH_LINK) ? {expC, v[7:1]} : {v[0], v[7:1]};
    if (op == RROT_OP_WITH_LINK) expC = v[0];
    if (!d) expAcc = res;
    got = 1'b0;
    @(posedge clk_sys);
    mem[idx] = v;
    issue <= 1'b1;
    instr <= '{opcode: op, dest: d, index: idx};
    @(posedge clk_sys);
    issue <= 1'b0;
    for (int i = 0; i < 8 && !got; i++) begin
      @(posedge clk_sys);
      #1;
      got = (done === 1'b1);
    end
    if (!got) begin
      n_errors++;
      end_of_test();
    end
    chk("fileWr", d ? fileWr : {fileWr.en, 16'h0}, {d, d ? {idx, res} : 16'h0});
    chk("workAcc", {9'h0, workAcc}, {9'h0, expAcc});
    chk("carryFlag", {16'h0, carryFlag}, {16'h0, expC});
  endtask
  task automatic s_link();
    run_op(RROT_OP_WITH_LINK, 1'b0, 8'h00, 8'he6);
    run_op(RROT_OP_WITH_LINK, 1'b0, 8'h10, 8'h80);
    run_op(RROT_OP_WITH_LINK, 1'b1, 8'hff, 8'h01);
  endtask
  task automatic s_plain();
    run_op(RROT_OP_PLAIN, 1'b1, 8'h00, 8'hd7);
    run_op(RROT_OP_PLAIN, 1'b0, 8'h7f, 8'h01);
  endtask
  task automatic s_freeze();
    logic got;
    got = 1'b0;
    @(posedge clk_sys);
    mem[8'h21] = 8'h55;
    issue <= 1'b1;
    instr <= '{opcode: RROT_OP_PLAIN, dest: 1'b0, index: 8'h21};
    @(posedge clk_sys);
    issue <= 1'b0;
    clkEn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("frozen busy", {16'h0, busy}, 17'h1);
    chk("frozen done", {16'h0, done}, 17'h0);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    for (int i = 0; i < 8 && !got; i++) begin
      @(posedge clk_sys);
      #1;
      got = (done === 1'b1);
    end
    if (!got) begin
      n_errors++;
      end_of_test();
    end
    expAcc = 8'haa;
    chk("frozen workAcc", {9'h0, workAcc}, {9'h0, expAcc});
    chk("frozen carryFlag", {16'h0, carryFlag}, {16'h0, expC});
  endtask
  task automatic s_refuse();
    @(posedge clk_sys);
    issue <= 1'b1;
    instr <= '{opcode: 7'h0d, dest: 1'b0, index: 8'h00};
    @(posedge clk_sys);
    issue <= 1'b0;
    #1;
    chk("busy", {16'h0, busy}, 17'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("reset", {7'h0, busy, carryFlag, workAcc}, 17'h0);
    s_link();
    s_plain();
    s_freeze();
    s_refuse();
    end_of_test();
  end
endmodule
